// file: logic/tiop_consts.vh
// Constants for the timed I/O port block: register map, field positions, resets and rates.
//
// Overview of operation
// - Ports of one, four, eight, sixteen and thirty-two bits reach the pins.
// - Every pin of a port shares one direction: all input or all output.
// - A port drives its pins, or samples them optionally waiting for a pin condition.
// - Each port access by the core completes in a single cycle.
// - Pin data passes a shift stage plus a transfer register in both directions.
// - Each port has a 16-bit counter that can time the transfer moment.
// - Software reads the counter anytime and may delay transfers until a count.
// - Every transfer captures the current counter value as a timestamp.
// - An enabled link removes the port output drive from the pins it shares.
// - An enabled narrower port takes shared pins from a wider port.
// - Unshared pins of the wider port stay with the wider port.
// - A port always works at its full width, whatever pins it lost.
// - Six clock blocks; block 0 is the reference clock at 100 MHz.
// - Blocks 1 to 5 are individually programmable to other rates.
// - A clock block can take a 1-bit port pin as clock source.
// - Ports accept an incoming ready strobe and can make an outgoing strobe.
// - After reset every port is attached to clock block 0.
// - Port pin events go straight to the tile to wake a waiting core.
`ifndef TIOP_CONSTS_VH
`define TIOP_CONSTS_VH

`define TIOP_CLK_MHZ      125
`define TIOP_REF_MHZ      100
`define TIOP_NPORT        5
`define TIOP_NCLKBLK      6
`define TIOP_NPIN         32

// Port registers: byte address = port index * 0x10 + register offset.
`define TIOP_PORT_STRIDE  8'h10
`define TIOP_REG_CTRL     4'h0
`define TIOP_REG_DATA     4'h4
`define TIOP_REG_TIME     4'h8
`define TIOP_REG_STAMP    4'hc
`define TIOP_CLKBLK_BASE  8'h80
`define TIOP_IRQ_STATUS   8'hc0
`define TIOP_IRQ_MASK     8'hc4

// Port control register fields.
`define TIOP_CTRL_EN      0
`define TIOP_CTRL_DIR     1
`define TIOP_CTRL_TIMED   2
`define TIOP_CTRL_COND    3
`define TIOP_CTRL_STRB    4
`define TIOP_CTRL_CSEL_LO 5
`define TIOP_CTRL_CSEL_HI 7
`define TIOP_CTRL_LINK    8
`define TIOP_CTRL_CV_LO   16
`define TIOP_CTRL_CV_HI   31
`define TIOP_CTRL_RESET   32'h0000_0000

// Clock block configuration fields.
`define TIOP_CB_DIV_HI    7
`define TIOP_CB_SRC       8
`define TIOP_CB_RESET     9'h000

// Pins shared with the inter-chip link.
`define TIOP_LINK_PIN_LO  4
`define TIOP_LINK_PIN_HI  7

`endif

// file: logic/tiop_port.v
// One timed port: counter, transfer register, shift stage, timestamp and strobes.
`timescale 1ns/100ps
module tiop_port #(
  parameter W = 8
) (
  input  wire          i_clk,
  input  wire          i_rst_n,
  input  wire          i_tick,
  input  wire          i_en,
  input  wire          i_dir_out,
  input  wire          i_timed,
  input  wire          i_cond_en,
  input  wire          i_strb_en,
  input  wire [15:0]   i_cond_val,
  input  wire [15:0]   i_time,
  input  wire          i_wr,
  input  wire [31:0]   i_wr_data,
  input  wire          i_rd_pop,
  input  wire [W-1:0]  i_pins,
  input  wire          i_ready_in,
  output wire [W-1:0]  o_pins,
  output wire          o_oe,
  output wire          o_ready_out_strobe,
  output wire [31:0]   o_rx_data,
  output wire          o_rx_valid,
  output wire          o_tx_full,
  output wire [15:0]   o_count,
  output wire [15:0]   o_stamp,
  output wire          o_event
);
  localparam [5:0] SHIFTS = 32 / W;
  localparam CW = (W < 16) ? W : 16;

  reg  [15:0]  cnt_q;
  reg  [31:0]  tx_q;
  reg          tx_full_q;
  reg  [31:0]  sh_q;
  reg  [5:0]   left_q;
  reg  [31:0]  rx_q;
  reg          rx_valid_q;
  reg  [15:0]  stamp_q;
  reg  [W-1:0] pins_q;
  reg          strobe_q;
  reg          event_q;
  wire [31:0]  pin_ext;
  wire         at_time;
  wire         cond_ok;
  wire         in_ok;

  generate
    if (W < 32) begin : g_pad
      assign pin_ext = {{(32-W){1'b0}}, i_pins};
    end
    else begin : g_full
      assign pin_ext = i_pins;
    end
  endgenerate

  assign at_time = !i_timed || (cnt_q == i_time);
  assign cond_ok = !i_cond_en || (pin_ext[CW-1:0] == i_cond_val[CW-1:0]);
  assign in_ok   = !i_strb_en || i_ready_in;

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_q      <= 16'h0000;
      tx_q       <= 32'h0000_0000;
      tx_full_q  <= 1'b0;
      sh_q       <= 32'h0000_0000;
      left_q     <= 6'h00;
      rx_q       <= 32'h0000_0000;
      rx_valid_q <= 1'b0;
      stamp_q    <= 16'h0000;
      pins_q     <= {W{1'b0}};
      strobe_q   <= 1'b0;
      event_q    <= 1'b0;
    end
    else
    begin
      event_q <= 1'b0;
      if (i_tick)
        cnt_q <= cnt_q + 16'h0001;
      if (i_rd_pop)
        rx_valid_q <= 1'b0;
      if (i_wr)
      begin
        tx_q      <= i_wr_data;
        tx_full_q <= 1'b1;
      end
      if (!i_en)
      begin
        left_q   <= 6'h00;
        strobe_q <= 1'b0;
      end
      else if (i_tick && i_dir_out)
      begin
        strobe_q <= 1'b0;
        if (left_q != 6'h00)
        begin
          pins_q   <= sh_q[W-1:0];
          sh_q     <= sh_q >> W;
          left_q   <= left_q - 6'h01;
          strobe_q <= i_strb_en;
        end
        else if (tx_full_q && !i_wr && at_time)
        begin
          pins_q    <= tx_q[W-1:0];
          sh_q      <= tx_q >> W;
          left_q    <= SHIFTS - 6'h01;
          tx_full_q <= 1'b0;
          stamp_q   <= cnt_q;
          strobe_q  <= i_strb_en;
          event_q   <= 1'b1;
        end
      end
      else if (i_tick && !i_dir_out && in_ok)
      begin
        if (left_q != 6'h00)
        begin
          sh_q   <= (sh_q << W) | pin_ext;
          left_q <= left_q - 6'h01;
          if (left_q == 6'h01)
          begin
            rx_q       <= (sh_q << W) | pin_ext;
            rx_valid_q <= 1'b1;
            stamp_q    <= cnt_q;
            event_q    <= 1'b1;
          end
        end
        else if (at_time && cond_ok)
        begin
          sh_q   <= pin_ext;
          left_q <= SHIFTS - 6'h01;
          if (SHIFTS == 6'h01)
          begin
            rx_q       <= pin_ext;
            rx_valid_q <= 1'b1;
            stamp_q    <= cnt_q;
            event_q    <= 1'b1;
          end
        end
      end
    end
  end

  assign o_oe               = i_en && i_dir_out;
  assign o_pins             = pins_q;
  assign o_ready_out_strobe = strobe_q;
  assign o_rx_data          = rx_q;
  assign o_rx_valid         = rx_valid_q;
  assign o_tx_full          = tx_full_q;
  assign o_count            = cnt_q;
  assign o_stamp            = stamp_q;
  assign o_event            = event_q;
endmodule // tiop_port

// file: logic/tiop_top.v
// Timed I/O port block: APB registers, clock blocks, pin sharing and five ports.
`timescale 1ns/100ps
`include "tiop_consts.vh"
module tiop_top (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire        o_pready,
  output wire        o_pslverr,
  input  wire [31:0] i_pin,
  output wire [31:0] o_pin,
  output wire [31:0] o_pin_oe,
  input  wire [4:0]  i_ready_in,
  output wire [4:0]  o_ready_out_strobe,
  output wire        o_link_pins_taken,
  output wire [4:0]  o_wake,
  output wire        o_irq
);
  localparam NP = `TIOP_NPORT;
  localparam [7:0] REF_STEP = `TIOP_REF_MHZ;
  localparam [7:0] CLK_STEP = `TIOP_CLK_MHZ;

  reg          rst_s1_q;
  reg          rst_s2_q;
  wire         rst_n;
  reg  [31:0]  pin_s1_q;
  reg  [31:0]  pin_s2_q;
  reg  [31:0]  pin_s3_q;
  reg  [31:0]  pin_q;
  reg  [4:0]   rdy_s1_q;
  reg  [4:0]   rdy_s2_q;
  reg  [4:0]   rdy_s3_q;
  reg  [4:0]   rdy_q;
  reg  [31:0]  ctrl_q [0:NP-1];
  reg  [15:0]  time_q [0:NP-1];
  reg  [8:0]   cb_q [1:`TIOP_NCLKBLK-1];
  reg  [7:0]   div_q [1:`TIOP_NCLKBLK-1];
  reg  [7:0]   acc_q;
  reg          ref_tick_q;
  reg  [`TIOP_NCLKBLK-1:0] cb_tick_q;
  reg          src_last_q;
  reg  [4:0]   irq_st_q;
  reg  [4:0]   irq_mask_q;
  reg  [31:0]  prdata_q;
  reg          pslverr_q;
  reg  [31:0]  rdata_d;
  reg          hit_d;
  reg  [31:0]  pin_out_d;
  reg  [31:0]  pin_oe_d;
  wire         acc_wrap;
  wire         src_rise;
  wire         apb_go;
  wire         apb_wr;
  wire         apb_rd;
  wire [2:0]   sel_port;
  wire [3:0]   sel_reg;
  wire         port_space;
  wire [31:0]  p_pins [0:NP-1];
  wire [NP-1:0] p_oe;
  wire [NP-1:0] p_tick;
  wire [31:0]  rx_data [0:NP-1];
  wire [NP-1:0] rx_valid;
  wire [NP-1:0] tx_full;
  wire [15:0]  count [0:NP-1];
  wire [15:0]  stamp [0:NP-1];
  wire [NP-1:0] ev;
  wire         link_en;
  integer      k;
  integer      kp;
  integer      kc;
  integer      kd;
  integer      kr;

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // Pins are asynchronous; a level is only accepted once the later two stages agree.
  always @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_q <= 32'h0000_0000;
      pin_s2_q <= 32'h0000_0000;
      pin_s3_q <= 32'h0000_0000;
      pin_q    <= 32'h0000_0000;
      rdy_s1_q <= 5'h00;
      rdy_s2_q <= 5'h00;
      rdy_s3_q <= 5'h00;
      rdy_q    <= 5'h00;
    end
    else
    begin
      pin_s1_q <= i_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (kp = 0; kp < 32; kp = kp + 1)
        if (pin_s2_q[kp] == pin_s3_q[kp])
          pin_q[kp] <= pin_s3_q[kp];
      // Ready strobes come from outside too, so they pass the same filter.
      rdy_s1_q <= i_ready_in;
      rdy_s2_q <= rdy_s1_q;
      rdy_s3_q <= rdy_s2_q;
      for (kp = 0; kp < 5; kp = kp + 1)
        if (rdy_s2_q[kp] == rdy_s3_q[kp])
          rdy_q[kp] <= rdy_s3_q[kp];
    end
  end

  assign acc_wrap = ({1'b0, acc_q} + {1'b0, REF_STEP}) >= {1'b0, CLK_STEP};
  assign src_rise = pin_q[0] && !src_last_q;

  always @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_q      <= 8'h00;
      ref_tick_q <= 1'b0;
      cb_tick_q  <= 6'h00;
      src_last_q <= 1'b0;
      for (kc = 1; kc < `TIOP_NCLKBLK; kc = kc + 1)
        div_q[kc] <= 8'h00;
    end
    else
    begin
      src_last_q <= pin_q[0];
      if (acc_wrap)
        acc_q <= acc_q + REF_STEP - CLK_STEP;
      else
        acc_q <= acc_q + REF_STEP;
      ref_tick_q   <= acc_wrap;
      cb_tick_q[0] <= acc_wrap;
      for (kc = 1; kc < `TIOP_NCLKBLK; kc = kc + 1)
      begin
        cb_tick_q[kc] <= 1'b0;
        if (cb_q[kc][`TIOP_CB_SRC])
          cb_tick_q[kc] <= src_rise;
        else if (ref_tick_q)
        begin
          if (div_q[kc] >= cb_q[kc][`TIOP_CB_DIV_HI:0])
          begin
            div_q[kc]     <= 8'h00;
            cb_tick_q[kc] <= 1'b1;
          end
          else
            div_q[kc] <= div_q[kc] + 8'h01;
        end
      end
    end
  end

  assign apb_go     = i_psel && i_penable;
  assign apb_wr     = apb_go && i_pwrite;
  assign apb_rd     = apb_go && !i_pwrite;
  assign sel_port   = i_paddr[6:4];
  assign sel_reg    = i_paddr[3:0];
  assign port_space = !i_paddr[7] && (sel_port < NP) && (i_paddr[1:0] == 2'b00);

  always @*
  begin
    rdata_d = 32'h0000_0000;
    hit_d   = 1'b0;
    if (port_space)
    begin
      hit_d = 1'b1;
      case (sel_reg)
        `TIOP_REG_CTRL:  rdata_d = ctrl_q[sel_port];
        `TIOP_REG_DATA:  rdata_d = rx_data[sel_port];
        `TIOP_REG_TIME:  rdata_d = {13'h0000, rx_valid[sel_port], tx_full[sel_port],
                                    1'b0, count[sel_port]};
        `TIOP_REG_STAMP: rdata_d = {16'h0000, stamp[sel_port]};
        default:         hit_d = 1'b0;
      endcase
    end
    else if (i_paddr == `TIOP_IRQ_STATUS)
    begin
      hit_d   = 1'b1;
      rdata_d = {27'h0000000, irq_st_q};
    end
    else if (i_paddr == `TIOP_IRQ_MASK)
    begin
      hit_d   = 1'b1;
      rdata_d = {27'h0000000, irq_mask_q};
    end
    else
    begin
      for (kd = 1; kd < `TIOP_NCLKBLK; kd = kd + 1)
        if (i_paddr == `TIOP_CLKBLK_BASE + 8'h04 * kd[7:0])
        begin
          hit_d   = 1'b1;
          rdata_d = {23'h000000, cb_q[kd]};
        end
    end
  end

  always @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_st_q   <= 5'h00;
      irq_mask_q <= 5'h00;
      prdata_q   <= 32'h0000_0000;
      pslverr_q  <= 1'b0;
      for (kr = 0; kr < NP; kr = kr + 1)
      begin
        ctrl_q[kr] <= `TIOP_CTRL_RESET;
        time_q[kr] <= 16'h0000;
      end
      for (kr = 1; kr < `TIOP_NCLKBLK; kr = kr + 1)
        cb_q[kr] <= `TIOP_CB_RESET;
    end
    else
    begin
      if (i_psel && !i_penable)
      begin
        prdata_q  <= rdata_d;
        pslverr_q <= !hit_d;
      end
      if (apb_wr && port_space && sel_reg == `TIOP_REG_CTRL)
        ctrl_q[sel_port] <= i_pwdata;
      if (apb_wr && port_space && sel_reg == `TIOP_REG_TIME)
        time_q[sel_port] <= i_pwdata[15:0];
      if (apb_wr && i_paddr == `TIOP_IRQ_MASK)
        irq_mask_q <= i_pwdata[4:0];
      for (kr = 1; kr < `TIOP_NCLKBLK; kr = kr + 1)
        if (apb_wr && i_paddr == `TIOP_CLKBLK_BASE + 8'h04 * kr[7:0])
          cb_q[kr] <= i_pwdata[8:0];
      // New events win over a write-one-to-clear in the same cycle.
      if (apb_wr && i_paddr == `TIOP_IRQ_STATUS)
        irq_st_q <= (irq_st_q & ~i_pwdata[4:0]) | ev;
      else
        irq_st_q <= irq_st_q | ev;
    end
  end

  assign o_prdata  = prdata_q;
  assign o_pready  = 1'b1;
  assign o_pslverr = pslverr_q;
  assign o_irq     = |(irq_st_q & irq_mask_q);
  assign o_wake    = ev;

  genvar g;
  generate
    for (g = 0; g < NP; g = g + 1)
    begin : g_port
      localparam PW = (g == 0) ? 1 : (g == 1) ? 4 : (g == 2) ? 8 : (g == 3) ? 16 : 32;
      wire [PW-1:0] pout;
      // A block number past the last one gives no ticks rather than an unknown.
      assign p_tick[g] = (ctrl_q[g][`TIOP_CTRL_CSEL_HI:`TIOP_CTRL_CSEL_LO] < `TIOP_NCLKBLK) &&
                         cb_tick_q[ctrl_q[g][`TIOP_CTRL_CSEL_HI:`TIOP_CTRL_CSEL_LO]];
      if (PW < 32)
      begin : g_ext
        assign p_pins[g] = {{(32-PW){1'b0}}, pout};
      end
      else
      begin : g_noext
        assign p_pins[g] = pout;
      end
      tiop_port #(.W(PW)) u_port (
        .i_clk              (i_clk),
        .i_rst_n            (rst_n),
        .i_tick             (p_tick[g]),
        .i_en               (ctrl_q[g][`TIOP_CTRL_EN]),
        .i_dir_out          (ctrl_q[g][`TIOP_CTRL_DIR]),
        .i_timed            (ctrl_q[g][`TIOP_CTRL_TIMED]),
        .i_cond_en          (ctrl_q[g][`TIOP_CTRL_COND]),
        .i_strb_en          (ctrl_q[g][`TIOP_CTRL_STRB]),
        .i_cond_val         (ctrl_q[g][`TIOP_CTRL_CV_HI:`TIOP_CTRL_CV_LO]),
        .i_time             (time_q[g]),
        .i_wr               (apb_wr && port_space && sel_port == g &&
                             sel_reg == `TIOP_REG_DATA),
        .i_wr_data          (i_pwdata),
        .i_rd_pop           (apb_rd && port_space && sel_port == g &&
                             sel_reg == `TIOP_REG_DATA),
        .i_pins             (pin_q[PW-1:0]),
        .i_ready_in         (rdy_q[g]),
        .o_pins             (pout),
        .o_oe               (p_oe[g]),
        .o_ready_out_strobe (o_ready_out_strobe[g]),
        .o_rx_data          (rx_data[g]),
        .o_rx_valid         (rx_valid[g]),
        .o_tx_full          (tx_full[g]),
        .o_count            (count[g]),
        .o_stamp            (stamp[g]),
        .o_event            (ev[g])
      );
    end
  endgenerate

  // The link enable lives in the control word of the 1-bit port.
  assign link_en           = ctrl_q[0][`TIOP_CTRL_LINK];
  assign o_link_pins_taken = link_en;

  // Ports are visited widest first so the narrowest enabled one owns a pin.
  always @*
  begin
    pin_out_d = 32'h0000_0000;
    pin_oe_d  = 32'h0000_0000;
    for (k = 0; k < 32; k = k + 1)
    begin
      if (ctrl_q[4][`TIOP_CTRL_EN])
      begin
        pin_out_d[k] = p_pins[4][k];
        pin_oe_d[k]  = p_oe[4];
      end
      if (k < 16 && ctrl_q[3][`TIOP_CTRL_EN])
      begin
        pin_out_d[k] = p_pins[3][k];
        pin_oe_d[k]  = p_oe[3];
      end
      if (k < 8 && ctrl_q[2][`TIOP_CTRL_EN])
      begin
        pin_out_d[k] = p_pins[2][k];
        pin_oe_d[k]  = p_oe[2];
      end
      if (k < 4 && ctrl_q[1][`TIOP_CTRL_EN])
      begin
        pin_out_d[k] = p_pins[1][k];
        pin_oe_d[k]  = p_oe[1];
      end
      if (k < 1 && ctrl_q[0][`TIOP_CTRL_EN])
      begin
        pin_out_d[k] = p_pins[0][k];
        pin_oe_d[k]  = p_oe[0];
      end
      if (link_en && k >= `TIOP_LINK_PIN_LO && k <= `TIOP_LINK_PIN_HI)
      begin
        pin_out_d[k] = 1'b0;
        pin_oe_d[k]  = 1'b0;
      end
    end
  end

  assign o_pin    = pin_out_d;
  assign o_pin_oe = pin_oe_d;
endmodule // tiop_top

// file: verif/tiop_top_asserts.sv
// Port-level checker of the timed I/O port block, bound to its top module.
`timescale 1ns/100ps
module tiop_top_chk (
  input wire        i_clk,
  input wire        i_rst_n,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [7:0]  i_paddr,
  input wire [31:0] o_prdata,
  input wire        o_pready,
  input wire        o_pslverr,
  input wire [31:0] o_pin_oe,
  input wire [4:0]  o_ready_out_strobe,
  input wire        o_link_pins_taken,
  input wire [4:0]  o_wake,
  input wire        o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire acc = i_psel && i_penable;

  property p_no_wait;
    i_psel && !i_penable |=> o_pready;
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("access phase stalled");
  property p_unmapped;
    acc && i_paddr >= 8'hd0 |-> o_pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error on unmapped");
  property p_mapped;
    acc && i_paddr < 8'h50 && i_paddr[1:0] == 2'b00 |-> !o_pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("error on port register");
  property p_rd_hold;
    acc |=> $stable(o_prdata) && $stable(o_pslverr);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved early");
  property p_link_release;
    o_link_pins_taken |-> o_pin_oe[7:4] == 4'h0;
  endproperty
  a_link_release: assert property (p_link_release) else $error("link pins driven");
  property p_link_cause;
    $changed(o_link_pins_taken) |-> $past(acc && i_pwrite && i_paddr == 8'h00);
  endproperty
  a_link_cause: assert property (p_link_cause) else $error("link flag moved alone");
  property p_reset_quiet;
    $rose(i_rst_n) |-> o_pin_oe == 32'h0 && !o_irq ##1 o_pin_oe == 32'h0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("pins driven at reset");
  property p_irq_cause;
    $rose(o_irq) |-> |o_wake || $past(|o_wake) || $past(acc && i_pwrite && i_paddr == 8'hc4);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without event");
  property p_strobe_short;
    $rose(o_ready_out_strobe[4]) |-> ##[1:3] !o_ready_out_strobe[4];
  endproperty
  a_strobe_short: assert property (p_strobe_short) else $error("strobe too long");
endmodule // tiop_top_chk

bind tiop_top tiop_top_chk u_chk (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .o_prdata, .o_pready, .o_pslverr, .o_pin_oe, .o_ready_out_strobe, .o_link_pins_taken,
  .o_wake, .o_irq);

// file: verif/tiop_ext_model.sv
// Behavioural model of the hardware wired to the port pins.
`timescale 1ns/100ps
module tiop_ext_model (
  input  wire        i_clk,
  input  wire [31:0] i_drive,
  input  wire        i_ready,
  input  wire [31:0] i_dev_pin,
  input  wire [31:0] i_dev_oe,
  input  wire [4:0]  i_dev_strobe,
  output wire [31:0] o_pin,
  output wire [4:0]  o_ready_in,
  output reg  [7:0]  o_strobe_cnt
);
  reg prev_q;
  assign o_pin = (i_dev_oe & i_dev_pin) | (~i_dev_oe & i_drive);
  assign o_ready_in = {5{i_ready}};
  initial
  begin
    o_strobe_cnt = 8'h00;
    prev_q = 1'b0;
  end
  always @(posedge i_clk)
  begin
    prev_q <= i_dev_strobe[4];
    if (i_dev_strobe[4] && !prev_q)
      o_strobe_cnt <= o_strobe_cnt + 8'h01;
  end
endmodule // tiop_ext_model

// file: verif/testbench.sv
// Self-checking testbench of the timed I/O port block.
`timescale 1ns/100ps
module testbench;
  reg         i_clk;
  reg         i_rst_n;
  reg         i_psel;
  reg         i_penable;
  reg         i_pwrite;
  reg  [7:0]  i_paddr;
  reg  [31:0] i_pwdata;
  reg  [31:0] drive;
  reg         ready;
  wire [31:0] o_prdata;
  wire        o_pready;
  wire        o_pslverr;
  wire [31:0] pin_in;
  wire [31:0] o_pin;
  wire [31:0] o_pin_oe;
  wire [4:0]  ready_in;
  wire [4:0]  o_ready_out_strobe;
  wire        o_link_pins_taken;
  wire [4:0]  o_wake;
  wire        o_irq;
  wire [7:0]  strobe_cnt;
  integer     err_count;
  integer     checks_done;
  integer     k;
  integer     n;
  reg  [31:0] rd;
  reg  [31:0] t0;
  reg  [15:0] d;
  reg  [7:0]  s0;
  reg         slverr;

  tiop_top u_dut (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_pin(pin_in), .o_pin, .o_pin_oe,
    .i_ready_in(ready_in), .o_ready_out_strobe, .o_link_pins_taken, .o_wake, .o_irq);
  tiop_ext_model u_ext (.i_clk, .i_drive(drive), .i_ready(ready), .i_dev_pin(o_pin),
    .i_dev_oe(o_pin_oe), .i_dev_strobe(o_ready_out_strobe), .o_pin(pin_in),
    .o_ready_in(ready_in), .o_strobe_cnt(strobe_cnt));

  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task chk(input [31:0] seen, input [31:0] exp);
  begin
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  end
  endtask

  task apb(input [7:0] a, input w, input [31:0] v);
  begin
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= v;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1)
      @(posedge i_clk);
    rd = o_prdata;
    slverr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  end
  endtask

  task wr(input [7:0] a, input [31:0] v);
    apb(a, 1'b1, v);
  endtask

  task rd_chk(input [7:0] a, input [31:0] exp);
  begin
    apb(a, 1'b0, 32'h0);
    chk(rd, exp);
  end
  endtask

  task wait_wake;
  begin
    n = 0;
    while (o_wake[4] !== 1'b1 && n < 60)
    begin
      @(negedge i_clk);
      n = n + 1;
    end
    chk(o_wake[4], 1'b1);
  end
  endtask

  // The counter is read at two setup edges 53 cycles apart.
  task rate(input [15:0] lo, input [15:0] hi);
  begin
    apb(8'h48, 1'b0, 32'h0);
    t0 = rd;
    repeat (50) @(posedge i_clk);
    apb(8'h48, 1'b0, 32'h0);
    d = rd[15:0] - t0[15:0];
    chk(d >= lo && d <= hi, 1'b1);
  end
  endtask

  task quiet;
  begin
    repeat (8) @(posedge i_clk);
    apb(8'h44, 1'b0, 32'h0);
    repeat (20) @(posedge i_clk);
    apb(8'h48, 1'b0, 32'h0);
    chk(rd[18], 1'b0);
  end
  endtask

  task results;
  begin
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask

  initial
  begin
    #100000;
    err_count = err_count + 1;
    $display("mismatch at %0t: watchdog expired", $time);
    results;
  end

  initial
  begin
    {i_rst_n, i_psel, i_penable, i_pwrite, ready} = 5'h00;
    {i_paddr, i_pwdata, drive} = 72'h0;
    err_count = 0;
    checks_done = 0;
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    for (k = 0; k < 5; k = k + 1)
    begin
      rd_chk(8'(16 * k), 32'h0);
      rd_chk(8'(8'h84 + 4 * k), 32'h0);
    end
    chk(o_pin_oe, 32'h0);
    wr(8'hf0, 32'hffff_ffff);
    chk(slverr, 1'b1);
    rd_chk(8'hf0, 32'h0);
    $display("reset and map test done");
    rate(16'd41, 16'd44);
    wr(8'h84, 32'h3);
    rd_chk(8'h84, 32'h3);
    wr(8'h40, 32'h21);
    rate(16'd9, 16'd12);
    wr(8'h88, 32'h100);
    wr(8'h40, 32'h41);
    apb(8'h48, 1'b0, 32'h0);
    t0 = rd;
    for (k = 0; k < 6; k = k + 1)
    begin
      drive[0] <= 1'b1;
      repeat (6) @(posedge i_clk);
      drive[0] <= 1'b0;
      repeat (6) @(posedge i_clk);
    end
    apb(8'h48, 1'b0, 32'h0);
    chk(rd[15:0] - t0[15:0], 32'd6);
    $display("counter test done");
    wr(8'h40, 32'h13);
    s0 = strobe_cnt;
    wr(8'h44, 32'ha5c3_0f96);
    wait_wake;
    chk(o_pin, 32'ha5c3_0f96);
    chk(o_pin_oe, 32'hffff_ffff);
    apb(8'h4c, 1'b0, 32'h0);
    t0 = rd;
    apb(8'h48, 1'b0, 32'h0);
    d = rd[15:0] - t0[15:0];
    chk(d >= 1 && d <= 12, 1'b1);
    chk(strobe_cnt, s0 + 8'h01);
    rd_chk(8'hc0, 32'h10);
    chk(o_irq, 1'b0);
    wr(8'hc4, 32'h10);
    @(negedge i_clk);
    chk(o_irq, 1'b1);
    wr(8'hc0, 32'h10);
    @(negedge i_clk);
    chk(o_irq, 1'b0);
    wr(8'hc4, 32'h0);
    $display("output and interrupt test done");
    apb(8'h48, 1'b0, 32'h0);
    t0 = rd;
    wr(8'h48, {16'h0, t0[15:0] + 16'd30});
    wr(8'h40, 32'h17);
    wr(8'h44, 32'h5a3c_f069);
    repeat (10) @(negedge i_clk);
    chk(o_pin, 32'ha5c3_0f96);
    wait_wake;
    chk(o_pin, 32'h5a3c_f069);
    rd_chk(8'h4c, {16'h0, t0[15:0] + 16'd30});
    wr(8'h00, 32'h100);
    @(negedge i_clk);
    chk(o_link_pins_taken, 1'b1);
    chk(o_pin_oe, 32'hffff_ff0f);
    wr(8'h00, 32'h0);
    wr(8'h40, 32'h13);
    wr(8'h44, 32'h0);
    wait_wake;
    wr(8'h00, 32'h3);
    wr(8'h04, 32'hffff_ffff);
    repeat (8) @(negedge i_clk);
    chk($countones(o_pin), 32'd1);
    chk(o_pin_oe, 32'hffff_ffff);
    wr(8'h00, 32'h0);
    $display("timed and sharing test done");
    wr(8'h40, 32'h1);
    drive <= 32'h3c5a_9617;
    repeat (12) @(posedge i_clk);
    rd_chk(8'h44, 32'h3c5a_9617);
    drive <= 32'h0000_1111;
    wr(8'h40, 32'h1234_0009);
    quiet;
    drive <= 32'habcd_1234;
    repeat (12) @(posedge i_clk);
    rd_chk(8'h44, 32'habcd_1234);
    wr(8'h40, 32'h11);
    quiet;
    ready <= 1'b1;
    repeat (12) @(posedge i_clk);
    apb(8'h48, 1'b0, 32'h0);
    chk(rd[18], 1'b1);
    $display("input test done");
    results;
  end
endmodule // testbench
